// [hw/secfail_debug_capture.sv]
// Security-fail FCS marking and 512-byte capture buffer with AHB-Lite CSRs.
// Assumes both datapath sides on hclk; FCS bytes arrive as the last 4 beats.
`include "secfail_debug_defines.svh"
module secfail_debug_capture
  import secfail_debug_pkg::*;
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire byte_beat_t   egr_in,
  input  wire frame_class_t egr_class,
  input  wire byte_beat_t   igr_in,
  input  wire frame_class_t igr_class,
  output byte_beat_t        egr_out,
  output byte_beat_t        igr_out
);

  // Register file
  logic        side_ingress;
  logic [8:0]  max_size;
  logic        capture_arm;
  logic        debug_mark;
  logic [31:0] sa_first_pkt_trigger_lo;
  logic [31:0] sa_first_pkt_trigger_hi;
  logic [17:0] global_fail_event_mask;
  logic [12:0] per_sa_fail_event_mask;
  logic [7:0]  pkt_count;
  logic        buf_full;
  logic [8:0]  buffer_write_pointer;
  logic [31:0] mem [`BUF_WORDS];

  // Fault code assembly; events already in per-direction order
  function automatic logic [31:0] fault_code(input frame_class_t c,
                                             input logic ingress);
    logic [13:0] g;
    logic [9:0]  s;
    logic [5:0]  top;
    g   = ingress ? c.global_evt[13:0] : {5'h00, c.global_evt[8:0]};
    s   = ingress ? c.sa_evt[9:0] : {4'h0, c.sa_evt[5:0]};
    top = c.sa_hit ? c.sa_ptr : {3'h0, c.is_ctrl, c.tag_class};
    fault_code = {1'b1, c.sa_hit, top, g, s};
  endfunction

  function automatic logic is_fail(input frame_class_t c,
                                   input logic [17:0] gm,
                                   input logic [12:0] sm);
    is_fail = |(c.global_evt & gm) | |(c.sa_evt & sm);
  endfunction

  // FCS marking per direction; last four beats carry the FCS
  function automatic logic [7:0] mark_byte(input logic [7:0] d,
                                           input logic [31:0] code,
                                           input logic [1:0] left);
    mark_byte = code[{left, 3'b000} +: 8];
  endfunction

  // Each direction holds the last 4 bytes so the FCS can be swapped
  // once the frame's classification arrives with the final beat.
  byte_beat_t  dly [2][4];
  logic [2:0]  fill [2];
  logic [31:0] code_q [2];
  logic        mark_q [2];
  logic [1:0]  left_q [2];
  byte_beat_t  in_b [2];
  frame_class_t cls [2];
  assign in_b[0] = egr_in;
  assign in_b[1] = igr_in;
  assign cls[0]  = egr_class;
  assign cls[1]  = igr_class;

  genvar gd;
  generate
    for (gd = 0; gd < 2; gd++) begin : g_dir
      wire        fail_now = in_b[gd].valid && in_b[gd].eof &&
                             is_fail(cls[gd], global_fail_event_mask,
                                     per_sa_fail_event_mask);
      wire [31:0] code_now = fault_code(cls[gd], gd == 1);
      wire        shift    = in_b[gd].valid;
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          for (int k = 0; k < 4; k++) dly[gd][k] <= '0;
          mark_q[gd] <= 1'b0;
          code_q[gd] <= 32'h0000_0000;
          left_q[gd] <= 2'h0;
        end else begin
          if (shift) begin
            dly[gd][0] <= in_b[gd];
            for (int k = 1; k < 4; k++) dly[gd][k] <= dly[gd][k-1];
          end
          if (fail_now && debug_mark) begin
            mark_q[gd] <= 1'b1;
            code_q[gd] <= code_now;
            left_q[gd] <= 2'h3;
          end else if (shift && mark_q[gd]) begin
            left_q[gd] <= left_q[gd] - 2'h1;
            if (left_q[gd] == 2'h0) mark_q[gd] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Output beat: delayed by four valid beats; FCS bytes swapped when marked.
  // Trade-off: the tail flushes only as further bytes arrive.
  always_comb begin
    egr_out = dly[0][3];
    igr_out = dly[1][3];
    egr_out.valid = dly[0][3].valid && egr_in.valid;
    igr_out.valid = dly[1][3].valid && igr_in.valid;
    if (mark_q[0])
      egr_out.data = mark_byte(dly[0][3].data, code_q[0], left_q[0]);
    if (mark_q[1])
      igr_out.data = mark_byte(dly[1][3].data, code_q[1], left_q[1]);
  end

  // Capture datapath on the selected side
  wire byte_beat_t   cap_in  = side_ingress ? igr_in : egr_in;
  wire frame_class_t cap_cls = side_ingress ? igr_class : egr_class;
  wire               cap_ing = side_ingress;
  wire [5:0] sa_idx  = cap_cls.sa_ptr;
  wire [63:0] trig   = {sa_first_pkt_trigger_hi, sa_first_pkt_trigger_lo};
  wire sa_trig_hit   = cap_cls.sa_hit && trig[sa_idx];
  wire cap_fail      = is_fail(cap_cls, global_fail_event_mask,
                                per_sa_fail_event_mask);

  cap_state_t  state;
  cap_state_t  next_state;
  logic [8:0]  pkt_base;
  logic [8:0]  pkt_bytes;
  logic        pkt_trunc;
  logic [31:0] pkt_code;

  wire [8:0] cap_limit = (max_size > `MAX_DATA_BYTES) ? `MAX_DATA_BYTES
                                                      : max_size;
  wire [9:0] room      = 10'(`BUF_BYTES) - 10'(pkt_base) - 10'd8;
  wire [9:0] lim_room  = (10'(cap_limit) < room) ? 10'(cap_limit) : room;
  wire       byte_ok   = cap_in.valid && (10'(pkt_bytes) < lim_room);
  wire       overflow  = cap_in.valid && !byte_ok;
  wire [8:0] data_addr = pkt_base + 9'd8 + pkt_bytes;
  wire       start_ok  = capture_arm && !buf_full && cap_in.valid &&
                         cap_in.sof && room > 10'd8;
  wire       eof_beat  = cap_in.valid && cap_in.eof;
  wire       keep      = cap_fail || sa_trig_hit;
  wire [31:0] hdr0     = {22'h000000, pkt_trunc, pkt_bytes};

  always_comb begin
    next_state = state;
    unique case (state)
      cap_idle: if (start_ok) next_state = cap_data;
      cap_data: if (eof_beat) next_state = keep ? cap_hdr0 : cap_idle;
      cap_hdr0: next_state = cap_hdr1;
      cap_hdr1: next_state = cap_idle;
    endcase
  end

  // AHB-Lite slave: zero wait states, always OKAY
  logic        ph_valid;
  logic        ph_write;
  logic [11:0] ph_addr;
  wire  take    = hsel && hready && htrans[1];
  wire  wr_now  = ph_valid && ph_write;
  wire  win_hit = ph_addr >= `OFS_WINDOW_BASE &&
                  ph_addr < `OFS_WINDOW_BASE + 12'h200;
  wire [6:0] win_idx = ph_addr[8:2];
  wire  arm_wr  = wr_now && ph_addr == `OFS_CAPTURE_ARM;
  wire  rearm   = arm_wr && hwdata[0] && !capture_arm;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr  <= 12'h000;
    end else if (hready) begin
      ph_valid <= take;
      ph_write <= hwrite;
      ph_addr  <= {haddr[11:2], 2'b00};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      side_ingress            <= 1'b0;
      max_size                <= `RST_MAX_SIZE;
      capture_arm             <= 1'b0;
      debug_mark              <= 1'b0;
      global_fail_event_mask  <= 18'h00000;
      per_sa_fail_event_mask  <= 13'h0000;
    end else if (wr_now) begin
      if (ph_addr == `OFS_CAPTURE_CONTROL) begin
        side_ingress <= hwdata[16];
        max_size     <= hwdata[8:0];
      end
      if (arm_wr) capture_arm <= hwdata[0];
      if (ph_addr == `OFS_DEBUG_MARK) debug_mark <= hwdata[0];
      if (ph_addr == `OFS_GLOBAL_MASK)
        global_fail_event_mask <= hwdata[17:0];
      if (ph_addr == `OFS_SA_MASK) per_sa_fail_event_mask <= hwdata[12:0];
    end
  end

  // Trigger bits: hardware clear on capture wins over software write
  wire trig_clr = state == cap_hdr1 && pkt_code[`SA_HIT_BIT];
  wire [63:0] clr_mask = trig_clr ? (64'h1 << pkt_code[29:24]) : 64'h0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sa_first_pkt_trigger_lo <= 32'h0000_0000;
      sa_first_pkt_trigger_hi <= 32'h0000_0000;
    end else begin
      sa_first_pkt_trigger_lo <= ((wr_now && ph_addr == `OFS_TRIGGER_LO) ?
        hwdata : sa_first_pkt_trigger_lo) & ~clr_mask[31:0];
      sa_first_pkt_trigger_hi <= ((wr_now && ph_addr == `OFS_TRIGGER_HI) ?
        hwdata : sa_first_pkt_trigger_hi) & ~clr_mask[63:32];
    end
  end

  // Capture state, pointers and status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state                <= cap_idle;
      pkt_base             <= 9'h000;
      pkt_bytes            <= 9'h000;
      pkt_trunc            <= 1'b0;
      pkt_code             <= 32'h0000_0000;
      pkt_count            <= 8'h00;
      buf_full             <= 1'b0;
      buffer_write_pointer <= 9'h000;
    end else begin
      state <= next_state;
      if (rearm) begin
        pkt_base             <= 9'h000;
        pkt_count            <= 8'h00;
        buf_full             <= 1'b0;
        buffer_write_pointer <= 9'h000;
      end
      if (state == cap_idle && start_ok) begin
        pkt_bytes <= 9'h001;
        pkt_trunc <= 1'b0;
      end else if (state == cap_data) begin
        if (byte_ok) pkt_bytes <= pkt_bytes + 9'h001;
        if (overflow) pkt_trunc <= 1'b1;
        if (eof_beat) pkt_code <= fault_code(cap_cls, cap_ing);
      end
      if (state == cap_hdr1) begin
        pkt_count <= pkt_count + 8'h01;
        pkt_base  <= pkt_base + 9'd8 + ((pkt_bytes + 9'h003) & 9'h1FC);
        buffer_write_pointer <= pkt_base + 9'd8 +
                                ((pkt_bytes + 9'h003) & 9'h1FC);
        if (10'(pkt_base) + 10'd8 + 10'(pkt_bytes) + 10'd11 >
            10'(`BUF_BYTES))
          buf_full <= 1'b1;
      end
    end
  end

  // Buffer write: bytes packed little-endian, headers at packet base.
  // First byte rides the start beat; later bytes only if still in limit.
  wire wr_byte = (state == cap_idle && start_ok) ||
                 (state == cap_data && byte_ok);
  wire [8:0] byte_addr = (state == cap_idle) ? pkt_base + 9'd8 : data_addr;
  always_ff @(posedge hclk) begin
    if (wr_byte)
      mem[byte_addr[8:2]][{byte_addr[1:0], 3'b000} +: 8] <= cap_in.data;
    if (state == cap_hdr0) mem[pkt_base[8:2]] <= hdr0;
    if (state == cap_hdr1) mem[pkt_base[8:2] + 7'h01] <= pkt_code;
  end

  // Read mux
  wire [31:0] status_word = {14'h0000, buffer_write_pointer, buf_full,
                             pkt_count};
  always_comb begin
    hrdata = 32'h0000_0000;
    if (ph_valid && !ph_write) begin
      if (win_hit) hrdata = mem[win_idx];
      else unique case (ph_addr)
        `OFS_CAPTURE_CONTROL: hrdata = {15'h0000, side_ingress, 7'h00,
                                        max_size};
        `OFS_CAPTURE_ARM:     hrdata = {31'h0, capture_arm};
        `OFS_CAPTURE_STATUS:  hrdata = status_word;
        `OFS_TRIGGER_LO:      hrdata = sa_first_pkt_trigger_lo;
        `OFS_TRIGGER_HI:      hrdata = sa_first_pkt_trigger_hi;
        `OFS_GLOBAL_MASK:     hrdata = {14'h0000, global_fail_event_mask};
        `OFS_SA_MASK:         hrdata = {19'h00000, per_sa_fail_event_mask};
        `OFS_DEBUG_MARK:      hrdata = {31'h0, debug_mark};
        default:              hrdata = 32'h0000_0000;
      endcase
    end
  end

endmodule // secfail_debug_capture

// [hw/secfail_debug_defines.svh]
// Offsets, field positions, reset values and sizes of the secfail debug block.
// Assumes inclusion by the design file, the port checker and the bench only.
`ifndef SECFAIL_DEBUG_DEFINES_SVH
`define SECFAIL_DEBUG_DEFINES_SVH
`define OFS_CAPTURE_CONTROL  12'h000
`define OFS_CAPTURE_ARM      12'h004
`define OFS_CAPTURE_STATUS   12'h008
`define OFS_TRIGGER_LO       12'h00C
`define OFS_TRIGGER_HI       12'h010
`define OFS_GLOBAL_MASK      12'h014
`define OFS_SA_MASK          12'h018
`define OFS_DEBUG_MARK       12'h01C
`define OFS_WINDOW_BASE      12'h200
`define BUF_WORDS            128
`define BUF_BYTES            512
`define MAX_DATA_BYTES       9'h1F8
`define RST_MAX_SIZE         9'h040
`define FCS_FAIL_BIT         31
`define SA_HIT_BIT           30
`define CTRL_BIT             26
`define GLOBAL_LSB           10
`endif

// [hw/secfail_debug_pkg.sv]
// Types shared by the secfail debug block.
// Assumes the defines header is on the include path.
package secfail_debug_pkg;
  // Per-frame classification presented at the end of the frame
  typedef struct packed {
    logic        sa_hit;
    logic [5:0]  sa_ptr;
    logic        is_ctrl;
    logic [1:0]  tag_class;
    logic [17:0] global_evt;
    logic [12:0] sa_evt;
  } frame_class_t;

  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic [7:0] data;
  } byte_beat_t;

  typedef enum logic [1:0] {
    cap_idle = 2'b00,
    cap_data = 2'b01,
    cap_hdr0 = 2'b11,
    cap_hdr1 = 2'b10
  } cap_state_t;
endpackage

// [testbench/secfail_debug_capture_props.sv]
// Port checker for the secfail debug block.
// Assumes binding to the top module; one clock, async low reset.
`include "secfail_debug_defines.svh"
module secfail_debug_capture_props
  import secfail_debug_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire byte_beat_t  egr_in,
  input wire byte_beat_t  igr_in,
  input wire byte_beat_t  egr_out,
  input wire byte_beat_t  igr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire        req = hsel && hready && htrans[1];
  wire        rd  = req && !hwrite && haddr[31:12] == 20'h00000;
  wire [11:0] ofs = haddr[11:0];
  logic [2:0] egr_seen;
  // Delay line holds no valid beat until four have gone in
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) egr_seen <= 3'h0;
    else if (egr_in.valid && egr_seen != 3'h4) egr_seen <= egr_seen + 3'h1;

  property p_ready; hreadyout && !hresp; endproperty
  a_ready: assert property (p_ready) else $error("bus stalled");
  property p_idle; !req |=> hrdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data off phase");
  property p_unmapped;
    rd && ofs inside {[12'h020:12'h1FC], [12'h400:12'hFFF]} |=> hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole read");
  property p_status; rd && ofs == `OFS_CAPTURE_STATUS |=> hrdata[31:18] == 14'h0;
  endproperty
  a_status: assert property (p_status) else $error("status spare bits");
  property p_control;
    rd && ofs == `OFS_CAPTURE_CONTROL |=> hrdata[31:17] == 15'h0 && hrdata[15:9] == 7'h0;
  endproperty
  a_control: assert property (p_control) else $error("control spare");
  property p_egr_gate; egr_out.valid |-> egr_in.valid; endproperty
  a_egr_gate: assert property (p_egr_gate) else $error("egress beat");
  property p_igr_gate; igr_out.valid |-> igr_in.valid; endproperty
  a_igr_gate: assert property (p_igr_gate) else $error("ingress beat");
  property p_egr_fill; egr_seen != 3'h4 |-> !egr_out.valid; endproperty
  a_egr_fill: assert property (p_egr_fill) else $error("early beat");
  cover property (egr_out.valid);
  cover property (igr_out.valid);
  cover property (rd && ofs == `OFS_CAPTURE_STATUS ##1 hrdata[7:0] != 8'h00);
endmodule // secfail_debug_capture_props

// [testbench/frame_source.sv]
// Model of one post-transform frame stream of the datapath.
// Assumes send is entered just after a rising clock edge.
module frame_source
  import secfail_debug_pkg::*;
(
  input  wire logic    clk,
  output byte_beat_t   beat,
  output frame_class_t cls
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    beat = '0;
    cls  = '0;
  end
  // Frames arrive whole and after the transform
  task automatic send(input int n, input logic [7:0] base,
                      input frame_class_t c);
    for (int i = 0; i < n; i++) begin
      beat <= '{1'b1, i == 0, i == n - 1, base + 8'(i)};
      cls  <= (i == n - 1) ? c : ~c;
      @(posedge clk);
    end
    // Idle lines toggle so stale data never passes
    beat <= '{1'b0, 1'b0, 1'b0, ~beat.data};
    cls  <= ~c;
  endtask
endmodule // frame_source

// [testbench/secfail_debug_capture_tb.sv]
// Self-checking bench for the secfail debug block.
// Assumes a zero-wait slave and two frame_source partners.
`include "secfail_debug_defines.svh"
module secfail_debug_capture_tb
  import secfail_debug_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] RO [9] = '{`OFS_CAPTURE_CONTROL, `OFS_CAPTURE_ARM,
    `OFS_CAPTURE_STATUS, `OFS_TRIGGER_LO, `OFS_TRIGGER_HI, `OFS_GLOBAL_MASK,
    `OFS_SA_MASK, `OFS_DEBUG_MARK, 12'h020};
  localparam logic [31:0] RV [9] = '{32'h40, 0, 0, 0, 0, 0, 0, 0, 0};
  logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]  haddr, hwdata, hrdata, rd;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  byte_beat_t   egr_in, igr_in, egr_out, igr_out;
  frame_class_t egr_class, igr_class, c1, c2, c3;
  int           miscompares, samples_checked, cycles;
  logic [7:0]   outq [$];
  logic [7:0]   iq [$];

  secfail_debug_capture dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .egr_in, .egr_class, .igr_in, .igr_class, .egr_out, .igr_out);
  frame_source src_e (.clk(hclk), .beat(egr_in), .cls(egr_class));
  frame_source src_i (.clk(hclk), .beat(igr_in), .cls(igr_class));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic stop_test();
    $display("miscompares=%0d samples_checked=%0d", miscompares,
             samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (egr_out.valid === 1'b1) outq.push_back(egr_out.data);
    if (igr_out.valid === 1'b1) iq.push_back(igr_out.data);
    if (cycles == 5000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Software waits on the packet count, never on a fixed delay
  task automatic poll(input logic [7:0] n);
    bus(1'b0, `OFS_CAPTURE_STATUS, 32'h0);
    repeat (20) if (rd[7:0] !== n) bus(1'b0, `OFS_CAPTURE_STATUS, 32'h0);
  endtask

  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'b010;
    {miscompares, samples_checked, cycles} = '0;
    c1 = '{1'b1, 6'h05, 1'b0, 2'b00, 18'h00001, 13'h0000};
    c2 = '{1'b0, 6'h00, 1'b1, 2'b11, 18'h00001, 13'h0001};
    c3 = '{1'b1, 6'h03, 1'b0, 2'b01, 18'h00000, 13'h0000};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (RO[i]) rdchk(RO[i], RV[i]);
    bus(1'b1, 12'h020, 32'hFFFF_FFFF);
    rdchk(12'h020, 32'h0);
    bus(1'b1, `OFS_GLOBAL_MASK, 32'h1);
    bus(1'b1, `OFS_DEBUG_MARK, 32'h1);
    src_e.send(8, 8'hA0, c1);
    @(posedge hclk);
    src_e.send(8, 8'hB0, c3);
    @(posedge hclk);
    chk({outq[0], outq[1], outq[2], outq[3]}, 32'hA0A1_A2A3);
    chk({outq[4], outq[5], outq[6], outq[7]}, 32'hC500_0400);
    bus(1'b1, `OFS_CAPTURE_CONTROL, 32'h10);
    bus(1'b1, `OFS_CAPTURE_ARM, 32'h1);
    src_e.send(24, 8'h10, c1);
    // Capture needs two header cycles before it sees the next start
    repeat (2) @(posedge hclk);
    src_e.send(8, 8'h40, c2);
    @(posedge hclk);
    poll(8'h02);
    chk(rd, 32'h0000_5002);
    bus(1'b1, `OFS_CAPTURE_ARM, 32'h0);
    rdchk(`OFS_WINDOW_BASE, 32'h210);
    rdchk(`OFS_WINDOW_BASE + 12'h004, 32'hC500_0400);
    rdchk(`OFS_WINDOW_BASE + 12'h018, 32'h8);
    rdchk(`OFS_WINDOW_BASE + 12'h01C, 32'h8700_0401);
    // Ingress side, no fail masks: only the SA trigger can capture
    bus(1'b1, `OFS_CAPTURE_CONTROL, 32'h0001_0040);
    bus(1'b1, `OFS_GLOBAL_MASK, 32'h0);
    bus(1'b1, `OFS_TRIGGER_LO, 32'h8);
    bus(1'b1, `OFS_CAPTURE_ARM, 32'h1);
    src_e.send(8, 8'h50, c3);
    @(posedge hclk);
    src_i.send(12, 8'h60, c3);
    @(posedge hclk);
    poll(8'h01);
    chk(rd, 32'h0000_2801);
    rdchk(`OFS_TRIGGER_LO, 32'h0);
    chk({iq[0], iq[1], iq[2], iq[3]}, 32'h6061_6263);
    bus(1'b1, `OFS_CAPTURE_ARM, 32'h0);
    rdchk(`OFS_WINDOW_BASE, 32'hC);
    stop_test();
  end
endmodule // secfail_debug_capture_tb

bind secfail_debug_capture secfail_debug_capture_props u_props (.hclk,
  .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
  .hresp, .egr_in, .igr_in, .egr_out, .igr_out);
